// ### hdl/fsrpg_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to CLK_SYS; first stage feeds only the second.
`timescale 1ns/1ps
module fsrpg_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // Reset loads the pins' idle pattern, so edge detectors see no false edge after it
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= rst_val;
      q    <= rst_val;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// ### hdl/fsrpg_top.sv
// Security-register access and power-on command gating of a serial flash.
// Assumes the SPI host drives CS_N, SCLK, SI (mode 0); all three are async pins.
// Functional notes
// - Security read accepted once the supply valid delay ends, even busy, and streams while clocks run.
// - Read: select, opcode, register shifted out on SO until deselect.
// - Bit 0 reports non-volatile factory lock of the protected area.
// - Bit 1 customer lock; once set, bit and protected area frozen.
// - In protected-area mode, main array access is refused.
// - Bit 4 volatile continuous program flag, resets to zero.
// - Security write needs no prior write enable.
// - Security write is opcode only; deselect off byte boundary discards it.
// - After power-up: standby, not deep power-down, write enable latch cleared.
// - During power-on reset logic held reset and all commands ignored.
// - Write-type commands ignored until write inhibit delay elapses.
// - Reads accepted after supply valid delay, before write inhibit ends.
// - Protected mode entered and left by lone enter and exit commands.
`timescale 1ns/1ps
module fsrpg_top
  import fsrpg_pkg::*;
#(
  parameter int SUPPLY_VALID  = SUPPLY_VALID_CYCLES,
  parameter int WRITE_INHIBIT = WRITE_INHIBIT_CYCLES
) (
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic CS_N,
  input  wire logic SCLK,
  input  wire logic SI,
  input  wire logic FACTORY_LOCK,
  input  wire logic CP_ACTIVE,
  input  wire logic BUSY,
  output logic      SO,
  output logic      SO_OE,
  output logic      WRITE_ENABLE_LATCH,
  output logic      CUSTOMER_LOCK_FLAG,
  output logic      PROTECTED_MODE,
  output logic      DEEP_POWER_DOWN,
  output logic      ARRAY_ACCESS_OK,
  output logic      READ_READY,
  output logic      WRITE_READY,
  output logic      WRITE_CMD_PULSE,
  output logic [7:0] CMD_CODE
);
  typedef struct packed {
    logic            sclk_d;
    logic [2:0]      bit_cnt;
    logic [7:0]      shreg;
    logic [7:0]      opcode;
    logic            op_valid;
    logic            extra;
    logic            reading;
    logic [7:0]      out_sh;
    logic [DELAY_W-1:0] delay;
    logic            read_ok;
    logic            write_ok;
    logic            write_enable_latch;
    logic            lock;
    logic            prot;
    logic            factory;
    logic            cp;
    logic            so;
    logic            so_oe;
    logic            wr_pulse;
    logic [7:0]      cmd_code;
    logic            arr_ok;
    logic            dpd;
  } fsrpg_state_t;

  fsrpg_state_t s, next_s;
  logic [2:0]   pins;

  fsrpg_sync #(.W(3)) u_sync (
    .clk     (CLK_SYS),
    .rst     (RST),
    .d       ({CS_N, SCLK, SI}),
    .rst_val (3'h5),
    .q       (pins)
  );

  logic cs_n_s, sclk_s, si_s, rise, fall;
  assign cs_n_s = pins[2];
  assign sclk_s = pins[1];
  assign si_s   = pins[0];
  assign rise   = sclk_s & ~s.sclk_d;
  assign fall   = ~sclk_s & s.sclk_d;

  // Write-type opcode decode, used only for the write pulse; deselect actions are gated by write_ok alone
  function automatic logic is_write_op(input logic [7:0] op);
    return op == OP_WRITE_ENABLE || op == OP_PAGE_PROGRAM || op == OP_CONT_PROGRAM ||
           op == OP_SECTOR_ERASE || op == OP_CHIP_ERASE || op == OP_WRITE_SECURITY ||
           op == OP_STATUS_WRITE;
  endfunction

  function automatic logic [7:0] sec_image(input fsrpg_state_t st);
    logic [7:0] v;
    v = SEC_RESERVED_VALUE;
    v[SEC_FACTORY_BIT] = st.factory;
    v[SEC_LOCK_BIT]    = st.lock;
    v[SEC_CP_BIT]      = st.cp;
    return v;
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic [7:0] nb;
    nb = {s.shreg[6:0], si_s};
    next_s = s;
    next_s.sclk_d   = sclk_s;
    next_s.wr_pulse = 1'b0;
    next_s.factory  = FACTORY_LOCK; // factory lock mirror
    next_s.cp       = CP_ACTIVE;    // volatile flag follows mode
    if (s.delay != DELAY_W'(WRITE_INHIBIT)) begin
      next_s.delay = s.delay + DELAY_W'(1);
    end
    if (s.delay >= DELAY_W'(SUPPLY_VALID)) begin
      next_s.read_ok = 1'b1;
    end
    if (s.delay >= DELAY_W'(WRITE_INHIBIT)) begin
      next_s.write_ok = 1'b1;
    end
    if (cs_n_s) begin
      // Deselect ends the frame; only opcode-only commands act here
      next_s.so_oe   = 1'b0;
      next_s.reading = 1'b0;
      next_s.bit_cnt = 3'h0;
      if (s.op_valid && !s.extra && s.bit_cnt == 3'h0 && s.write_ok) begin
        case (s.opcode)
          // no write enable needed; lock only ever sets
          OP_WRITE_SECURITY: if (!s.lock && !BUSY) next_s.lock = 1'b1;
          OP_WRITE_ENABLE:   next_s.write_enable_latch = 1'b1;
          OP_WRITE_DISABLE:  next_s.write_enable_latch = 1'b0;
          OP_ENTER_PROTECTED: next_s.prot = 1'b1;
          OP_EXIT_PROTECTED:  next_s.prot = 1'b0;
          default: ;
        endcase
      end
      next_s.op_valid = 1'b0;
      next_s.extra    = 1'b0;
    end else begin
      if (rise && !s.reading) begin
        next_s.shreg   = nb;
        next_s.bit_cnt = s.bit_cnt + 3'h1;
        if (s.op_valid) next_s.extra = 1'b1;
        if (s.bit_cnt == 3'h7 && !s.op_valid) begin
          next_s.opcode   = nb;
          next_s.op_valid = 1'b1;
          next_s.cmd_code = nb;
          // read accepted regardless of busy; read gate
          if (nb == OP_READ_SECURITY && s.read_ok) begin
            next_s.reading = 1'b1;
            next_s.out_sh  = sec_image(s);
            next_s.bit_cnt = 3'h0;
          end
          // pulse only once gate is open; locked protected area stays frozen
          if (is_write_op(nb) && s.write_ok &&
              !(s.prot && (s.lock || nb == OP_STATUS_WRITE))) begin
            next_s.wr_pulse = 1'b1;
          end
        end
      end
      // shift register contents out on falling edges, repeating
      if (s.reading && fall) begin
        next_s.so_oe = 1'b1;
        next_s.so    = s.out_sh[7];
        next_s.out_sh = (s.bit_cnt == 3'h7) ? sec_image(s) : {s.out_sh[6:0], 1'b0};
        next_s.bit_cnt = s.bit_cnt + 3'h1;
      end
    end
    // array gate registered so the pin comes straight from a flop
    next_s.arr_ok = next_s.read_ok & ~next_s.prot;
    // deep power-down is never entered by this block
    next_s.dpd    = 1'b0;
  end

  // synchronous reset holds everything; clears latch and standby
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // array access refused in protected mode
  assign ARRAY_ACCESS_OK    = s.arr_ok;
  assign SO                 = s.so;
  assign SO_OE              = s.so_oe;
  assign WRITE_ENABLE_LATCH = s.write_enable_latch;
  assign CUSTOMER_LOCK_FLAG = s.lock;
  assign PROTECTED_MODE     = s.prot;
  assign DEEP_POWER_DOWN    = s.dpd;
  assign READ_READY         = s.read_ok;
  assign WRITE_READY        = s.write_ok;
  assign WRITE_CMD_PULSE    = s.wr_pulse;
  assign CMD_CODE           = s.cmd_code;

  lock_sticky_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(s.lock) |-> s.lock) else $error("lock cleared");
  write_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    s.wr_pulse |-> $past(s.write_ok)) else $error("write before inhibit delay");
  read_first_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    s.write_ok |-> s.read_ok) else $error("read gate late");
  array_block_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    s.prot |-> !ARRAY_ACCESS_OK) else $error("array open in protected mode");
  so_release_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    cs_n_s |=> !s.so_oe) else $error("SO driven when deselected");
  wel_reset_a: assert property (@(posedge CLK_SYS)
    $fell(RST) |-> !s.write_enable_latch && !s.lock) else $error("latch not cleared");
  // flag tracks mode with one cycle lag
  cp_track_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    !$past(RST) |-> s.cp == $past(CP_ACTIVE)) else $error("cp flag stale");
  // lock only rises on a deselect
  lock_cs_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(s.lock) |-> $past(cs_n_s) && $past(s.bit_cnt) == 3'h0) else $error("lock off boundary");
endmodule

// ### pkg/fsrpg_pkg.sv
// Package for the flash security register and power-on gate block.
// Holds opcodes, register bit positions, reset values and delay counts.
package fsrpg_pkg;
  // Opcodes, left as parameters of plain value; the command set is not in scope
  localparam logic [7:0] OP_READ_SECURITY   = 8'h2B;
  localparam logic [7:0] OP_WRITE_SECURITY  = 8'h2F;
  localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_CONT_PROGRAM    = 8'hAD;
  localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE      = 8'h60;
  localparam logic [7:0] OP_ENTER_PROTECTED = 8'hB1;
  localparam logic [7:0] OP_EXIT_PROTECTED  = 8'hC1;
  localparam logic [7:0] OP_READ_DATA       = 8'h03;
  // Security register layout
  localparam int SEC_FACTORY_BIT = 0;
  localparam int SEC_LOCK_BIT    = 1;
  localparam int SEC_CP_BIT      = 4;
  localparam logic [7:0] SEC_RESERVED_VALUE = 8'h00;
  // Power-on delays in microseconds, then cycles at 100 MHz
  localparam int CLK_MHZ              = 100;
  localparam int SUPPLY_VALID_US      = 200;
  localparam int WRITE_INHIBIT_US     = 10000;
  localparam int SUPPLY_VALID_CYCLES  = SUPPLY_VALID_US * CLK_MHZ;
  localparam int WRITE_INHIBIT_CYCLES = WRITE_INHIBIT_US * CLK_MHZ;
  localparam int DELAY_W              = 24;
endpackage

// ### tb/flash_security_reg_and_power_on_gate_test.sv
// Self-checking bench for the security register and power-on gate.
// Assumes the host model drives the pins; delays shortened by parameter.
`timescale 1ns/1ps
module flash_security_reg_and_power_on_gate_test;
  import fsrpg_pkg::*;
  localparam int SV = 300;
  localparam int WI = 1500;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        fac     = 1'b1;
  logic        cp      = 1'b1;
  logic        busy    = 1'b0;
  logic        cs_n, sclk, si, so, so_oe, write_enable_latch, lock, prot, dpd;
  logic        arr_ok, rd_rdy, wr_rdy, wr_pulse;
  logic [7:0]  cmd_code;
  logic [15:0] rd;
  int          fails   = 0;
  int          checks  = 0;
  logic [7:0]  pulses  = 8'h00;
  logic        so_line;
  // Clock; reset comes from the sequence so it can be pulsed again mid-run
  always #5 clk_sys = ~clk_sys;
  // Released SO shows the inverse of its last bit, so a missing enable is caught
  assign so_line = so_oe ? so : ~so;
  // Count write pulses; each stands one cycle, so each edge sees it once
  always @(posedge clk_sys) begin
    if (wr_pulse === 1'b1) begin
      pulses <= pulses + 8'h01;
    end
  end
  fsrpg_top #(.SUPPLY_VALID(SV), .WRITE_INHIBIT(WI)) dut_u (
    .CLK_SYS(clk_sys), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .SI(si),
    .FACTORY_LOCK(fac), .CP_ACTIVE(cp), .BUSY(busy), .SO(so), .SO_OE(so_oe),
    .WRITE_ENABLE_LATCH(write_enable_latch), .CUSTOMER_LOCK_FLAG(lock), .PROTECTED_MODE(prot),
    .DEEP_POWER_DOWN(dpd), .ARRAY_ACCESS_OK(arr_ok), .READ_READY(rd_rdy),
    .WRITE_READY(wr_rdy), .WRITE_CMD_PULSE(wr_pulse), .CMD_CODE(cmd_code));
  fsrpg_host host_u (.clk(clk_sys), .so(so_line), .cs_n(cs_n), .sclk(sclk), .si(si));
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Sequence; flags read one step after the edge so updates have landed
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 chk({write_enable_latch, lock, prot, dpd, rd_rdy, wr_rdy, wr_pulse, so_oe}, 8'h00);
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int n = 0; n < 3000 && rd_rdy !== 1'b1; n++) @(posedge clk_sys);
    #1 chk({6'h00, rd_rdy, wr_rdy}, 8'h02);
    host_u.frame(OP_WRITE_ENABLE, 0, rd);
    #1 chk({7'h00, write_enable_latch}, 8'h00);
    chk(cmd_code, OP_WRITE_ENABLE);
    host_u.frame(OP_WRITE_SECURITY, 0, rd);
    #1 chk({7'h00, lock}, 8'h00);
    chk(pulses, 8'h00);
    host_u.frame(OP_READ_SECURITY, 16, rd);
    chk(rd[15:8], 8'h11);
    chk(rd[7:0], 8'h11);
    for (int n = 0; n < 3000 && wr_rdy !== 1'b1; n++) @(posedge clk_sys);
    #1 chk({7'h00, wr_rdy}, 8'h01);
    @(posedge clk_sys);
    fac  <= 1'b0;
    cp   <= 1'b0;
    host_u.frame(OP_WRITE_SECURITY, 1, rd);
    #1 chk({7'h00, lock}, 8'h00);
    chk(pulses, 8'h01);
    @(posedge clk_sys);
    busy <= 1'b1;
    host_u.frame(OP_READ_SECURITY, 16, rd);
    chk(rd[15:8], 8'h00);
    chk(rd[7:0], 8'h00);
    host_u.frame(OP_WRITE_SECURITY, 0, rd);
    #1 chk({7'h00, lock}, 8'h00);
    @(posedge clk_sys);
    busy <= 1'b0;
    host_u.frame(OP_WRITE_SECURITY, 0, rd);
    #1 chk({7'h00, lock}, 8'h01);
    chk(pulses, 8'h03);
    host_u.frame(OP_READ_SECURITY, 8, rd);
    chk(rd[7:0], 8'h02);
    host_u.frame(OP_ENTER_PROTECTED, 0, rd);
    #1 chk({6'h00, prot, arr_ok}, 8'h02);
    host_u.frame(OP_PAGE_PROGRAM, 0, rd);
    #1 chk(cmd_code, OP_PAGE_PROGRAM);
    chk(pulses, 8'h03);
    host_u.frame(OP_EXIT_PROTECTED, 0, rd);
    #1 chk({6'h00, prot, arr_ok}, 8'h01);
    host_u.frame(OP_WRITE_ENABLE, 0, rd);
    #1 chk({6'h00, write_enable_latch, dpd}, 8'h02);
    chk(pulses, 8'h04);
    host_u.frame(OP_WRITE_DISABLE, 0, rd);
    #1 chk({7'h00, write_enable_latch}, 8'h00);
    host_u.frame(OP_WRITE_ENABLE, 0, rd);
    #1 chk({7'h00, write_enable_latch}, 8'h01);
    // Second power-on reset in mid-run: latch and both gates must drop
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({4'h0, write_enable_latch, prot, rd_rdy, wr_rdy}, 8'h00);
    print_verdict();
  end
  // Watchdog sized well above the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end
endmodule

// ### tb/fsrpg_host.sv
// SPI host model: mode 0 frames, opcode MSB first.
// Assumes a free-running clk; SCLK stands low outside frames.
`timescale 1ns/1ps
module fsrpg_host (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sclk,
  output logic      si
);
  localparam int HALF = 6; // Half SCLK period in clk cycles, 60 ns at the 10 ns bench clock
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b1;
  end
  // one framed command
  // SO taken just before each rise; SI toggles once the opcode is out
  task automatic frame(input logic [7:0] op, input int extra, output logic [15:0] rd);
    logic [7:0] sh;
    sh = op;
    rd = '0;
    @(posedge clk);
    cs_n <= 1'b0;
    si   <= sh[7];
    for (int i = 0; i < 8 + extra; i++) begin
      repeat (HALF) @(posedge clk);
      rd = {rd[14:0], so};
      sclk <= 1'b1;
      sh = {sh[6:0], 1'b0};
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
      si   <= (i < 7) ? sh[7] : ~si;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (HALF) @(posedge clk);
  endtask
endmodule
